//--- hdl/uif_event_flags.sv
// uif_event_flags: usb event flags, enables, error summary and interrupt request with an apb slave
// assumes engine event inputs are same-clock pulses, line-state inputs come from pins
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module uif_event_flags
    import uif_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic stall_event_i,
    input wire logic frame_start_event_i,
    input wire logic bus_reset_event_i,
    input wire logic disconnect_event_i,
    input wire logic token_done_event_i,
    input wire logic [FLAG_W-1:0] error_event_i,
    input wire logic line_se0_i,
    input wire logic line_j_i,
    input wire logic line_k_i,
    input wire logic bus_activity_i,
    output logic status_fifo_advance_o,
    output logic usb_irq_request_o,
    output logic host_role_enable_o
);
    // refuse counts that the counters cannot serve
    if (IDLE_CYCLES < 1) begin : g_idle_check
        $error("IDLE_CYCLES must be at least one");
    end
    if (ATTACH_QUIET_CYC < 1 || WAKEUP_K_CYC < 1) begin : g_line_check
        $error("line timing counts must be at least one");
    end

    // one width serves all three line timers, with room for the overshoot step
    localparam int unsigned LINE_TOP = (ATTACH_QUIET_CYC > WAKEUP_K_CYC) ? ATTACH_QUIET_CYC : WAKEUP_K_CYC;
    localparam int unsigned CNT_TOP = (LINE_TOP > IDLE_CYCLES) ? LINE_TOP : IDLE_CYCLES;
    localparam int unsigned CNT_W = $clog2(CNT_TOP + 2) + 1;
    localparam logic [CNT_W-1:0] QUIET_MAX = CNT_W'(ATTACH_QUIET_CYC);
    localparam logic [CNT_W-1:0] K_MAX = CNT_W'(WAKEUP_K_CYC);
    localparam logic [CNT_W-1:0] IDLE_MAX = CNT_W'(IDLE_CYCLES);

    logic [FLAG_W-1:0] usb_event_flags_reg;
    logic [FLAG_W-1:0] usb_event_enables_reg;
    logic [FLAG_W-1:0] error_flags_reg;
    logic [FLAG_W-1:0] error_enable_register_reg;
    logic host_role_enable_reg;
    logic suspend_reg;
    logic [1:0] se0_sync_reg;
    logic [1:0] j_sync_reg;
    logic [1:0] k_sync_reg;
    logic [1:0] act_sync_reg;
    logic [CNT_W-1:0] quiet_cnt_reg;
    logic [CNT_W-1:0] k_cnt_reg;
    logic [CNT_W-1:0] idle_cnt_reg;
    logic attached_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic advance_reg;
    logic irq_reg;

    logic wr_access;
    logic rd_access;
    logic addr_ok;
    logic [FLAG_W-1:0] wr_byte;
    logic se0_s;
    logic j_s;
    logic k_s;
    logic act_s;
    logic [FLAG_W-1:0] ev_set;
    logic [FLAG_W-1:0] ev_clr;
    logic [FLAG_W-1:0] err_clr;
    logic connect_evt;
    logic wakeup_evt;
    logic quiet_evt;
    logic error_summary;
    logic wr_flags;
    logic wr_enables;
    logic wr_err_flags;
    logic wr_err_enables;
    logic wr_control;
    logic [DATA_W-1:0] rd_mux;

    // two-cycle apb access phase, the access acts in its first cycle and pready answers in the second
    assign wr_access = psel_i & penable_i & pwrite_i & ~pready_reg;
    assign rd_access = psel_i & penable_i & ~pwrite_i & ~pready_reg;
    assign wr_byte = pwdata_i[FLAG_W-1:0];
    assign addr_ok = (paddr_i == OFF_EVENT_FLAGS) | (paddr_i == OFF_EVENT_ENABLES)
        | (paddr_i == OFF_ERROR_FLAGS) | (paddr_i == OFF_ERROR_ENABLES) | (paddr_i == OFF_CONTROL);

    // one decode per register keeps each write block to its own concern
    assign wr_flags = wr_access & (paddr_i == OFF_EVENT_FLAGS);
    assign wr_enables = wr_access & (paddr_i == OFF_EVENT_ENABLES);
    assign wr_err_flags = wr_access & (paddr_i == OFF_ERROR_FLAGS);
    assign wr_err_enables = wr_access & (paddr_i == OFF_ERROR_ENABLES);
    assign wr_control = wr_access & (paddr_i == OFF_CONTROL);

    // pin inputs pass two flops before any logic reads them
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            se0_sync_reg <= 2'h0;
            j_sync_reg <= 2'h0;
            k_sync_reg <= 2'h0;
            act_sync_reg <= 2'h0;
        end else begin
            se0_sync_reg <= {se0_sync_reg[0], line_se0_i};
            j_sync_reg <= {j_sync_reg[0], line_j_i};
            k_sync_reg <= {k_sync_reg[0], line_k_i};
            act_sync_reg <= {act_sync_reg[0], bus_activity_i};
        end
    end
    // only the second stage feeds logic, the first may be metastable
    assign se0_s = se0_sync_reg[1];
    assign j_s = j_sync_reg[1];
    assign k_s = k_sync_reg[1];
    assign act_s = act_sync_reg[1];

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            quiet_cnt_reg <= '0;
        end else if (act_s | se0_s) begin
            quiet_cnt_reg <= '0;
        end else if (quiet_cnt_reg < QUIET_MAX) begin
            quiet_cnt_reg <= quiet_cnt_reg + CNT_W'(1);
        end
    end
    // attach fires once per connection, rearmed by se0
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            attached_reg <= 1'b0;
        end else if (se0_s | ~host_role_enable_reg) begin
            attached_reg <= 1'b0;
        end else if (connect_evt) begin
            attached_reg <= 1'b1;
        end
    end
    assign connect_evt = host_role_enable_reg & ~se0_s & ~attached_reg & (quiet_cnt_reg == QUIET_MAX);

    // counting one past the limit stops a second pulse in the same stretch
    // k-state persistence count
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            k_cnt_reg <= '0;
        end else if (!k_s) begin
            k_cnt_reg <= '0;
        end else if (k_cnt_reg <= K_MAX) begin
            k_cnt_reg <= k_cnt_reg + CNT_W'(1);
        end
    end
    assign wakeup_evt = k_s & (k_cnt_reg == K_MAX);

    // a long idle stretch parks the count instead of wrapping and refiring
    // idle (j-state) count, pulses once per idle stretch
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            idle_cnt_reg <= '0;
        end else if (!j_s || act_s) begin
            idle_cnt_reg <= '0;
        end else if (idle_cnt_reg <= IDLE_MAX) begin
            idle_cnt_reg <= idle_cnt_reg + CNT_W'(1);
        end
    end
    assign quiet_evt = j_s & ~act_s & (idle_cnt_reg == IDLE_MAX);

    // only enabled error flags feed the summary
    assign error_summary = |(error_flags_reg & error_enable_register_reg);

    always_comb begin
        // bit 1 stays clear here; the summary path owns it
        ev_set = '0;
        ev_set[BIT_STALL] = stall_event_i;
        ev_set[BIT_CONNECT] = connect_evt;
        ev_set[BIT_WAKEUP] = wakeup_evt;
        ev_set[BIT_QUIET] = quiet_evt;
        ev_set[BIT_TOKEN] = token_done_event_i;
        ev_set[BIT_FRAME] = frame_start_event_i;
        ev_set[BIT_RESET_DETACH] = host_role_enable_reg ? disconnect_event_i : bus_reset_event_i;
    end

    // write one clears; error summary bit is read-only
    // the summary bit is masked out of the clear
    assign ev_clr = wr_flags ? (wr_byte & EVENT_W1C_MASK) : '0;
    assign err_clr = wr_err_flags ? (wr_byte & ERROR_W1C_MASK) : '0;

    // set wins over a same-cycle clear
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            usb_event_flags_reg <= FLAGS_RESET;
        end else begin
            usb_event_flags_reg <= (usb_event_flags_reg & ~ev_clr) | ev_set;
            usb_event_flags_reg[BIT_ERROR] <= error_summary;
        end
    end

    // error flags, set wins over a same-cycle clear
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            error_flags_reg <= FLAGS_RESET;
        end else begin
            error_flags_reg <= (error_flags_reg & ~err_clr) | error_event_i;
        end
    end

    // token-done clear advances the status fifo
    // a clear of an already clear flag does not step the fifo
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            advance_reg <= 1'b0;
        end else begin
            advance_reg <= ev_clr[BIT_TOKEN] & usb_event_flags_reg[BIT_TOKEN];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            usb_event_enables_reg <= FLAGS_RESET;
        end else if (wr_enables) begin
            usb_event_enables_reg <= wr_byte;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            error_enable_register_reg <= FLAGS_RESET;
        end else if (wr_err_enables) begin
            error_enable_register_reg <= wr_byte;
        end
    end

    // suspend is only stored; it gates nothing in this block
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            host_role_enable_reg <= 1'b0;
            suspend_reg <= 1'b0;
        end else if (wr_control) begin
            host_role_enable_reg <= pwdata_i[CTL_HOST];
            suspend_reg <= pwdata_i[CTL_SUSPEND];
        end
    end

    // registered so the request never glitches on a decode
    // irq is or of gated flags
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(usb_event_flags_reg & usb_event_enables_reg);
        end
    end

    always_comb begin
        rd_mux = '0;
        case (paddr_i)
            OFF_EVENT_FLAGS: rd_mux = {{(DATA_W-FLAG_W){1'b0}}, usb_event_flags_reg};
            OFF_EVENT_ENABLES: rd_mux = {{(DATA_W-FLAG_W){1'b0}}, usb_event_enables_reg};
            OFF_ERROR_FLAGS: rd_mux = {{(DATA_W-FLAG_W){1'b0}}, error_flags_reg};
            OFF_ERROR_ENABLES: rd_mux = {{(DATA_W-FLAG_W){1'b0}}, error_enable_register_reg};
            OFF_CONTROL: rd_mux = {{(DATA_W-2){1'b0}}, suspend_reg, host_role_enable_reg};
            default: rd_mux = '0;
        endcase
    end

    // read data is zero outside the answer cycle
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            prdata_reg <= '0;
        end else if (rd_access) begin
            prdata_reg <= rd_mux;
        end else begin
            prdata_reg <= '0;
        end
    end

    // one wait state: answer the cycle after the access phase opens
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= psel_i & penable_i & ~pready_reg;
        end
    end

    // unmapped addresses answer with an error; writes there land nowhere
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= psel_i & penable_i & ~pready_reg & ~addr_ok;
        end
    end

    // every output comes straight from a flop
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign status_fifo_advance_o = advance_reg;
    assign usb_irq_request_o = irq_reg;
    assign host_role_enable_o = host_role_enable_reg;
endmodule : uif_event_flags
`default_nettype wire

//--- hdl/uif_pkg.sv
// uif_pkg: register map, field positions and timing constants of the usb event flag block
// assumes a 100 MHz module clock and a 32-bit apb register port
package uif_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FLAG_W = 8;
    // register byte addresses
    localparam logic [ADDR_W-1:0] OFF_EVENT_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLES = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ERROR_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ERROR_ENABLES = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h10;
    // event flag bit positions
    localparam int unsigned BIT_STALL = 7;
    localparam int unsigned BIT_CONNECT = 6;
    localparam int unsigned BIT_WAKEUP = 5;
    localparam int unsigned BIT_QUIET = 4;
    localparam int unsigned BIT_TOKEN = 3;
    localparam int unsigned BIT_FRAME = 2;
    localparam int unsigned BIT_ERROR = 1;
    localparam int unsigned BIT_RESET_DETACH = 0;
    // control register fields
    localparam int unsigned CTL_HOST = 0;
    localparam int unsigned CTL_SUSPEND = 1;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] ERROR_W1C_MASK = 8'hFF;
    localparam logic [FLAG_W-1:0] EVENT_W1C_MASK = 8'hFD;
    // timing
    localparam int unsigned ATTACH_QUIET_NS = 2500;
    localparam int unsigned WAKEUP_K_NS = 2500;
    localparam int unsigned IDLE_US = 3000;
    localparam int unsigned ATTACH_QUIET_CYC = (ATTACH_QUIET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned WAKEUP_K_CYC = (WAKEUP_K_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned IDLE_CYC = IDLE_US * (CLK_HZ / 1_000_000);
endpackage : uif_pkg

//--- verif/tb.sv
// tb: register and event tests of the event flag block with a usb side model
// assumes a 100 MHz clock and a shortened idle count
`timescale 1ns/100ps
`default_nettype none
module tb
    import uif_pkg::*;
;
    typedef struct {logic [3:0] k; logic [1:0] m; int n; logic [7:0] f;} uif_row_type;
    uif_row_type rows [8] = '{'{4'h0, 2'h0, 0, 8'h80}, '{4'h1, 2'h0, 0, 8'h04}, '{4'h4, 2'h0, 0, 8'h08},
        '{4'h2, 2'h0, 0, 8'h01}, '{4'h3, 2'h0, 0, 8'h00}, '{4'h6, 2'h0, 0, 8'h02},
        '{4'hF, 2'h2, 270, 8'h20}, '{4'hF, 2'h1, 70, 8'h10}};
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, rdy, err, e, irq, fifo, host;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prd, q;
    logic [3:0] kind = 4'h0, ln;
    logic [1:0] mode = 2'h0;
    logic [4:0] ev;
    logic [7:0] er;
    int failures = 0, total_checks = 0, cycles = 0, fifo_count = 0;
    uif_event_flags #(.IDLE_CYCLES(50)) u_uif_event_flags (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(err), .stall_event_i(ev[0]), .frame_start_event_i(ev[1]),
        .bus_reset_event_i(ev[2]), .disconnect_event_i(ev[3]), .token_done_event_i(ev[4]), .error_event_i(er),
        .line_se0_i(ln[3]), .line_k_i(ln[2]), .line_j_i(ln[1]), .bus_activity_i(ln[0]),
        .status_fifo_advance_o(fifo), .usb_irq_request_o(irq), .host_role_enable_o(host));
    uif_side u_uif_side (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .go_i(go), .kind_i(kind), .mode_i(mode), .event_o(ev),
        .error_o(er), .line_o(ln));
    initial forever #5 mclk_i = ~mclk_i;
    // the whole run needs about 900 cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (fifo === 1'b1) fifo_count++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        pen <= 1'b1;
        do @(posedge mclk_i); while (rdy !== 1'b1);
        q = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(q, x);
    endtask : rd
    task automatic fire(input logic [3:0] k);
        @(posedge mclk_i);
        go <= 1'b1;
        kind <= k;
        @(posedge mclk_i);
        go <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : fire
    task automatic clear_all();
        apb(1'b1, OFF_ERROR_FLAGS, 32'hFF);
        apb(1'b1, OFF_EVENT_FLAGS, 32'hFF);
    endtask : clear_all
    initial begin
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd(OFF_EVENT_ENABLES, 32'h0);
        apb(1'b1, OFF_CONTROL, 32'h2);
        apb(1'b1, OFF_EVENT_ENABLES, 32'hFFFFFFFF);
        rd(OFF_EVENT_ENABLES, 32'hFF);
        apb(1'b1, OFF_ERROR_ENABLES, 32'hFE);
        foreach (rows[i]) begin
            mode <= rows[i].m;
            if (rows[i].k != 4'hF) fire(rows[i].k);
            repeat (rows[i].n) @(posedge mclk_i);
            rd(OFF_EVENT_FLAGS, rows[i].f);
            check(irq, rows[i].f != 8'h00);
            mode <= 2'h0;
            clear_all();
            rd(OFF_EVENT_FLAGS, 32'h0);
            check(irq, 1'b0);
        end
        fire(4'h0);
        apb(1'b1, OFF_EVENT_FLAGS, 32'h7F);
        rd(OFF_EVENT_FLAGS, 32'h80);
        apb(1'b1, OFF_EVENT_ENABLES, 32'h7F);
        @(posedge mclk_i);
        check(irq, 1'b0);
        fire(4'h5);
        rd(OFF_EVENT_FLAGS, 32'h80);
        fire(4'h6);
        apb(1'b1, OFF_EVENT_FLAGS, 32'h82);
        rd(OFF_EVENT_FLAGS, 32'h02);
        apb(1'b1, OFF_EVENT_ENABLES, 32'hFD);
        @(posedge mclk_i);
        check(irq, 1'b0);
        clear_all();
        apb(1'b1, OFF_CONTROL, 32'h3);
        check(host, 1'b1);
        fire(4'h2);
        fire(4'h3);
        rd(OFF_EVENT_FLAGS, 32'h01);
        apb(1'b1, OFF_EVENT_ENABLES, 32'hFE);
        @(posedge mclk_i);
        check(irq, 1'b0);
        clear_all();
        mode <= 2'h1;
        repeat (270) @(posedge mclk_i);
        rd(OFF_EVENT_FLAGS, 32'h50);
        mode <= 2'h0;
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd(OFF_EVENT_FLAGS, 32'h0);
        rd(OFF_EVENT_ENABLES, 32'h0);
        rd(8'h40, 32'h0);
        check(e, 1'b1);
        check(fifo_count, 32'd1);
        report_and_stop();
    end
endmodule : tb
bind uif_event_flags uif_chk u_uif_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .status_fifo_advance_o(status_fifo_advance_o),
    .usb_irq_request_o(usb_irq_request_o), .host_role_enable_o(host_role_enable_o));
`default_nettype wire

//--- verif/uif_event_flags_assertions.sv
// uif_chk: apb and irq timing checks on the event flag block
// bound to the top module by the bench
`timescale 1ns/100ps
`default_nettype none
module uif_chk
    import uif_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic status_fifo_advance_o,
    input wire logic usb_irq_request_o,
    input wire logic host_role_enable_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    wire taken = psel_i && penable_i && !pready_o;
    wire ctl_wr = taken && pwrite_i && paddr_i == OFF_CONTROL;
    one_wait_a: assert property (taken |=> pready_o ##1 !pready_o)
        else $error("ready not one wait state");
    upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    unmapped_read_a: assert property (taken && paddr_i > OFF_CONTROL |=> pslverr_o && prdata_o == 32'h00000000)
        else $error("unmapped access not refused");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i |=> !usb_irq_request_o && !host_role_enable_o)
        else $error("outputs active after reset");
    fifo_step_a: assert property (status_fifo_advance_o |->
        pready_o && pwrite_i && paddr_i == OFF_EVENT_FLAGS && pwdata_i[BIT_TOKEN])
        else $error("fifo advance without token clear");
    host_load_a: assert property (ctl_wr |=> host_role_enable_o == $past(pwdata_i[CTL_HOST]))
        else $error("host bit not loaded");
    host_hold_a: assert property (!ctl_wr |=> $stable(host_role_enable_o))
        else $error("host bit changed alone");
    irq_clear_a: assert property ($fell(usb_irq_request_o) |->
        $past(psel_i && pwrite_i, 2) || $past(psel_i && pwrite_i, 3))
        else $error("irq fell without a write");
endmodule : uif_chk
`default_nettype wire

//--- verif/uif_side.sv
// uif_side: usb engine event pulses and line levels for the event flag block
// assumes go_i is a one-cycle request from the bench
`timescale 1ns/100ps
`default_nettype none
module uif_side (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic go_i,
    input wire logic [3:0] kind_i,
    input wire logic [1:0] mode_i,
    output logic [4:0] event_o,
    output logic [7:0] error_o,
    output logic [3:0] line_o
);
    logic tog;
    always_ff @(posedge mclk_i) begin
        event_o <= go_i && kind_i < 4'h5 ? 5'h01 << kind_i : 5'h00;
        error_o <= go_i && kind_i > 4'h4 ? 8'h01 << (kind_i - 4'h5) : 8'h00;
        if (!reset_n_i) begin
            tog <= 1'b0;
        end else begin
            tog <= ~tog;
        end
    end
    // line levels: {se0, k, j, activity}
    // busy mode holds activity high and toggles j and k so that no quiet count can start
    assign line_o = mode_i == 2'h0 ? {1'b0, ~tog, tog, 1'b1} : 4'h1 << mode_i;
endmodule : uif_side
`default_nettype wire
